// ===== common/anp_pkg.sv
// Constants and carrier types for the next-page register bank
package anp_pkg;

    // Bus geometry
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 16;

    // Register indexes; the byte address is four times the index
    localparam logic [7:0]  EXP_INDEX       = 8'h06;
    localparam logic [7:0]  NPT_INDEX       = 8'h0E;
    localparam logic [7:0]  EXP_ADDR        = 8'(EXP_INDEX * 4);
    localparam logic [7:0]  NPT_ADDR        = 8'(NPT_INDEX * 4);

    // Storage places for received next pages
    localparam logic [7:0]  RX_STORE_ALT    = 8'h08;
    localparam logic [7:0]  RX_STORE_BASE   = 8'h05;

    // Expansion status field positions
    localparam int          EXP_LP_AN_BIT   = 0;
    localparam int          EXP_PAGE_RX_BIT = 1;
    localparam int          EXP_LOC_NP_BIT  = 2;
    localparam int          EXP_LP_NP_BIT   = 3;
    localparam int          EXP_PD_FLT_BIT  = 4;
    localparam int          EXP_RX_LOC_BIT  = 5;
    localparam int          EXP_LOC_CTL_BIT = 6;

    // Local next-page capability, a constant of the device
    localparam logic        LOCAL_NP_ABLE   = 1'b1;

    // Next-page transmit field positions
    localparam int          NPT_NP_BIT      = 15;
    localparam int          NPT_RSVD_BIT    = 14;
    localparam int          NPT_MP_BIT      = 13;
    localparam int          NPT_ACK2_BIT    = 12;
    localparam int          NPT_TOG_BIT     = 11;
    localparam int          NPT_CODE_MSB    = 10;

    // Reset values
    localparam logic        NPT_NP_RST      = 1'b0;
    localparam logic        NPT_MP_RST      = 1'b1;
    localparam logic        NPT_ACK2_RST    = 1'b0;
    localparam logic        NPT_TOG_RST     = 1'b0;
    localparam logic [10:0] NPT_CODE_RST    = 11'h001;
    localparam logic        EXP_RX_LOC_RST  = 1'b0;
    localparam logic        EXP_LOC_CTL_RST = 1'b0;

    // Status reported by the line-side negotiation logic
    typedef struct packed {
        logic page_rx;
        logic lp_an_able;
        logic pd_fault;
        logic lp_np_able;
    } anp_line_status_t;

    // Next page handed to the line side for sending
    typedef struct packed {
        logic        next_page;
        logic        message_page;
        logic        second_acknowledge;
        logic        toggle;
        logic [10:0] code;
    } anp_np_word_t;

endpackage

// ===== logic/anp_lh_bit.sv
// Latching-high status bit, cleared by a completed read
`timescale 1ns/1ps
module anp_lh_bit (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Event and clear
    input  wire logic event_in,
    input  wire logic read_clr,
    // Latched state
    output logic      latching_high_status
);

    // A new event in the clearing cycle wins, so no event is lost
    wire logic next_latching_high_status = event_in | (latching_high_status & ~read_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latching_high_status <= 1'b0;
        end else begin
            latching_high_status <= next_latching_high_status;
        end
    end

endmodule

// ===== logic/anp_regs.sv
// APB register bank for auto-negotiation expansion status and next-page transmit
`timescale 1ns/1ps

// Behaviour
// - Page-received flag latches high on a new page, resets to 0.
// - Read-only bit shows link partner auto-negotiation ability; resets 0.
// - Location-control bit 1 lets bit 5 choose the next-page store.
// - Location bit 1 stores pages at 08h, 0 stores at 05h.
// - Parallel detection fault bit latches high; resets to 0.
// - Read-only bit shows link partner next-page ability; resets 0.
// - Local next-page capability bit always reads 1.
// - Next-page transmit word sits at index 0Eh of each port page.
// - Bit 15 writable, resets 0; 1 means more next pages follow.
// - Bit 14 reserved, always reads 0.
// - Bit 13 writable, 1 formatted page, 0 unformatted; resets 1.
// - Bit 12 writable compliance flag, resets 0.
// - Bit 11 read-only toggle flips after each next page exchanged.
// - Bits 10:0 writable code field, resets to 001h.
module anp_regs (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // Line-side status from the negotiation logic
    input  wire anp_pkg::anp_line_status_t line_status,
    input  wire logic                    np_sent,
    // Line-side next-page request
    output anp_pkg::anp_np_word_t        np_word,
    output logic                         np_pending,
    output logic [7:0]                   rx_store_index
);

    // Bus phase decode
    wire logic setup_phase  = psel & ~penable;
    wire logic access_done  = psel & penable & pready;
    wire logic hit_exp      = (paddr == anp_pkg::EXP_ADDR);
    wire logic hit_npt      = (paddr == anp_pkg::NPT_ADDR);
    wire logic hit_any      = hit_exp | hit_npt;
    wire logic wr_done      = access_done & pwrite & hit_any;
    wire logic rd_done      = access_done & ~pwrite & hit_any;
    wire logic wr_exp       = wr_done & hit_exp;
    wire logic wr_npt       = wr_done & hit_npt;
    wire logic rd_exp       = rd_done & hit_exp;
    // The upper byte lane carries bits 15:8, the lower 7:0
    wire logic lane_lo      = pstrb[0];
    wire logic lane_hi      = pstrb[1];

    // Stored control fields
    logic        loc_ctl;
    logic        rx_loc;
    logic        tx_np;
    logic        tx_mp;
    logic        tx_ack2;
    logic        tx_tog;
    logic [10:0] tx_code;

    // Latching-high flags
    logic page_rx_lh;
    logic pd_fault_lh;

    // Read data is taken at the setup edge, so an event latched in that same
    // edge was never reported; only bits that the read returned as 1 are cleared
    wire logic clr_page_rx  = rd_exp & prdata[anp_pkg::EXP_PAGE_RX_BIT];
    wire logic clr_pd_fault = rd_exp & prdata[anp_pkg::EXP_PD_FLT_BIT];

    anp_lh_bit u_page_rx (
        .pclk                 (pclk),
        .presetn              (presetn),
        .event_in             (line_status.page_rx),
        .read_clr             (clr_page_rx),
        .latching_high_status (page_rx_lh)
    );

    anp_lh_bit u_pd_fault (
        .pclk                 (pclk),
        .presetn              (presetn),
        .event_in             (line_status.pd_fault),
        .read_clr             (clr_pd_fault),
        .latching_high_status (pd_fault_lh)
    );

    // Live partner abilities are sampled so reads see a stable value
    logic lp_an_able;
    logic lp_np_able;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_an_able <= 1'b0;
            lp_np_able <= 1'b0;
        end else begin
            lp_an_able <= line_status.lp_an_able;
            lp_np_able <= line_status.lp_np_able;
        end
    end

    // Expansion status word
    logic [15:0] exp_word;

    always_comb begin
        exp_word                             = '0;
        exp_word[anp_pkg::EXP_LP_AN_BIT]     = lp_an_able;
        exp_word[anp_pkg::EXP_PAGE_RX_BIT]   = page_rx_lh;
        exp_word[anp_pkg::EXP_LOC_NP_BIT]    = anp_pkg::LOCAL_NP_ABLE;
        exp_word[anp_pkg::EXP_LP_NP_BIT]     = lp_np_able;
        exp_word[anp_pkg::EXP_PD_FLT_BIT]    = pd_fault_lh;
        exp_word[anp_pkg::EXP_RX_LOC_BIT]    = rx_loc;
        exp_word[anp_pkg::EXP_LOC_CTL_BIT]   = loc_ctl;
    end

    // Next-page transmit word
    logic [15:0] npt_word;

    always_comb begin
        npt_word                                   = '0;
        npt_word[anp_pkg::NPT_NP_BIT]              = tx_np;
        npt_word[anp_pkg::NPT_RSVD_BIT]            = 1'b0;
        npt_word[anp_pkg::NPT_MP_BIT]              = tx_mp;
        npt_word[anp_pkg::NPT_ACK2_BIT]            = tx_ack2;
        npt_word[anp_pkg::NPT_TOG_BIT]             = tx_tog;
        npt_word[anp_pkg::NPT_CODE_MSB:0]          = tx_code;
    end

    // Read mux, taken in the setup cycle and held through the access cycle
    wire logic [15:0] rd_word = hit_exp ? exp_word : (hit_npt ? npt_word : 16'h0000);

    // Write data split per lane
    wire logic [15:0] wdata16 = pwdata[15:0];

    // APB answer: pready rises one cycle after setup, so each access has
    // exactly one wait-free access cycle; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~hit_any;
            if (setup_phase && !pwrite) begin
                prdata <= {16'h0000, rd_word};
            end else if (access_done) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Expansion register writable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc_ctl <= anp_pkg::EXP_LOC_CTL_RST;
            rx_loc  <= anp_pkg::EXP_RX_LOC_RST;
        end else if (wr_exp && lane_lo) begin
            loc_ctl <= wdata16[anp_pkg::EXP_LOC_CTL_BIT];
            rx_loc  <= wdata16[anp_pkg::EXP_RX_LOC_BIT];
        end
    end

    // Store place: the location bit only counts while location control is on
    wire logic       store_alt        = loc_ctl & rx_loc;
    wire logic [7:0] next_store_index = store_alt ? anp_pkg::RX_STORE_ALT : anp_pkg::RX_STORE_BASE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_store_index <= anp_pkg::RX_STORE_BASE;
        end else begin
            rx_store_index <= next_store_index;
        end
    end

    // Transmit word writable fields; bits 14 and 11 ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_np   <= anp_pkg::NPT_NP_RST;
            tx_mp   <= anp_pkg::NPT_MP_RST;
            tx_ack2 <= anp_pkg::NPT_ACK2_RST;
        end else if (wr_npt && lane_hi) begin
            tx_np   <= wdata16[anp_pkg::NPT_NP_BIT];
            tx_mp   <= wdata16[anp_pkg::NPT_MP_BIT];
            tx_ack2 <= wdata16[anp_pkg::NPT_ACK2_BIT];
        end
    end

    // Code field spans both byte lanes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_code <= anp_pkg::NPT_CODE_RST;
        end else if (wr_npt) begin
            if (lane_hi) begin
                tx_code[10:8] <= wdata16[10:8];
            end
            if (lane_lo) begin
                tx_code[7:0] <= wdata16[7:0];
            end
        end
    end

    // Toggle flips once per next page the line side reports as exchanged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_tog <= anp_pkg::NPT_TOG_RST;
        end else if (np_sent) begin
            tx_tog <= ~tx_tog;
        end
    end

    // Pending flag: a write arms it, a sent page disarms it; a write in the
    // same cycle as a send wins, since it carries a fresh page
    wire logic next_np_pending = wr_npt | (np_pending & ~np_sent);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            np_pending <= 1'b0;
        end else begin
            np_pending <= next_np_pending;
        end
    end

    // Word offered to the line side, refreshed every cycle from the fields
    anp_pkg::anp_np_word_t next_np_word;

    always_comb begin
        next_np_word.next_page          = tx_np;
        next_np_word.message_page       = tx_mp;
        next_np_word.second_acknowledge = tx_ack2;
        next_np_word.toggle             = tx_tog;
        next_np_word.code               = tx_code;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            np_word <= '{next_page:          anp_pkg::NPT_NP_RST,
                         message_page:       anp_pkg::NPT_MP_RST,
                         second_acknowledge: anp_pkg::NPT_ACK2_RST,
                         toggle:             anp_pkg::NPT_TOG_RST,
                         code:               anp_pkg::NPT_CODE_RST};
        end else begin
            np_word <= next_np_word;
        end
    end

endmodule

// ===== tb/anp_line_partner.sv
// Line-side stand-in: reports partner abilities and events, takes offered next pages
`timescale 1ns/1ps
module anp_line_partner (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // Offered page and answer delay
    input wire anp_pkg::anp_np_word_t np_word,
    input wire logic                  np_pending,
    input wire logic [3:0]            delay,
    // Status back to the bank
    output anp_pkg::anp_line_status_t line_status,
    output logic                      np_sent
);
    anp_pkg::anp_np_word_t taken;
    logic [3:0]            cnt;

    initial begin
        line_status = '0;
        np_sent = 1'b0;
    end

    // A large delay lets several writes land before the page is taken
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            np_sent <= 1'b0;
            cnt <= 4'h0;
        end else if (np_pending && !np_sent && cnt >= delay) begin
            np_sent <= 1'b1;
            taken <= np_word;
            cnt <= 4'h0;
        end else begin
            np_sent <= 1'b0;
            cnt <= (np_pending && !np_sent) ? cnt + 4'h1 : 4'h0;
        end
    end

    task automatic pulse(input logic an, input logic np, input logic pg, input logic flt);
        @(posedge pclk);
        line_status <= '{page_rx: pg, lp_an_able: an, pd_fault: flt, lp_np_able: np};
        @(posedge pclk);
        line_status.page_rx <= 1'b0;
        line_status.pd_fault <= 1'b0;
    endtask
endmodule

// ===== tb/anp_regs_properties.sv
// Port assertions for the next-page register bank
`timescale 1ns/1ps
module anp_regs_properties (
    // Clock, reset and APB
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [3:0]                pstrb,
    input wire logic                      pready,
    input wire logic [31:0]               prdata,
    input wire logic                      pslverr,
    // Line side
    input wire anp_pkg::anp_line_status_t line_status,
    input wire logic                      np_sent,
    input wire anp_pkg::anp_np_word_t     np_word,
    input wire logic                      np_pending,
    input wire logic [7:0]                rx_store_index
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire done   = psel && penable && pready;
    wire at_exp = paddr == anp_pkg::EXP_ADDR;
    wire at_npt = paddr == anp_pkg::NPT_ADDR;
    wire wr_npt = done && pwrite && at_npt;
    wire wr_exp = done && pwrite && at_exp && pstrb[0];

    a_ready_one_cycle: assert property (done |=> !pready) else $error("pready held too long");
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    a_err_by_addr: assert property (pready |-> pslverr == !(at_exp || at_npt)) else $error("bad pslverr");
    a_rsvd_reads_zero: assert property (done && !pwrite && at_npt |-> !prdata[14] && prdata[31:16] == 16'h0000)
        else $error("reserved bits not zero");
    a_local_np_set: assert property (done && !pwrite && at_exp |-> prdata[2]) else $error("local bit clear");
    a_toggle_flips: assert property (np_sent |-> ##2 np_word.toggle != $past(np_word.toggle))
        else $error("toggle did not flip");
    a_pend_on_write: assert property (wr_npt |=> np_pending) else $error("write not pending");
    a_pend_cleared: assert property (np_sent && !wr_npt |=> !np_pending) else $error("pending stuck");
    a_store_alt: assert property (wr_exp && pwdata[6:5] == 2'b11 |-> ##2 rx_store_index == anp_pkg::RX_STORE_ALT)
        else $error("store index not alternate");
    a_store_base: assert property (wr_exp && pwdata[6:5] != 2'b11 |-> ##2 rx_store_index == anp_pkg::RX_STORE_BASE)
        else $error("store index not base");

    c_npt_write: cover property (wr_npt);
    c_sent: cover property (np_sent);
    c_unmapped: cover property (pready && pslverr);
endmodule

bind anp_regs anp_regs_properties u_anp_regs_properties (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .line_status, .np_sent, .np_word, .np_pending, .rx_store_index);

// ===== tb/anp_regs_tb_top.sv
// Self-checking bench for the next-page register bank
`timescale 1ns/1ps
module anp_regs_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, back = 1'b0;
    logic [7:0]  paddr = 8'h00, rx_store_index;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    logic [3:0]  pstrb = 4'hF, dly = 4'hF;
    logic        pready, pslverr, np_sent, np_pending, err;
    int          n_errors = 0, check_count = 0, cycles = 0;
    anp_pkg::anp_line_status_t line_status;
    anp_pkg::anp_np_word_t     np_word;
    localparam logic [7:0]  EXP = anp_pkg::EXP_ADDR, NPT = anp_pkg::NPT_ADDR;
    localparam logic [15:0] LOC_W [3] = '{16'h0060, 16'h0040, 16'h0020};
    localparam logic [7:0]  LOC_IX [3] = '{8'h08, 8'h05, 8'h05};

    always #10 pclk = ~pclk;

    anp_regs u_anp_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .prdata, .pslverr, .line_status, .np_sent, .np_word, .np_pending, .rx_store_index);
    anp_line_partner u_anp_line_partner (.pclk, .presetn, .np_word, .np_pending, .delay(dly), .line_status,
        .np_sent);

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // With more set, psel stays up so the next setup follows at once
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic more);
        if (!back) psel <= 1'b1;
        back = more;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        penable <= 1'b0;
        if (!more) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic more);
        acc(1'b0, a, 16'h0000, more);
        chk("prdata", rdata, exp);
    endtask

    task automatic wait_sent;
        int n;
        n = 0;
        while (np_pending !== 1'b0 && n < 64) begin
            @(posedge pclk);
            n++;
        end
        chk("np_pending", {31'h0, np_pending}, 32'h0000_0000);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("np_word", {17'h0, np_word}, 32'h0000_2001);
        chk("rx_store_index", {24'h0, rx_store_index}, 32'h0000_0005);
        rd(EXP, 32'h0000_0004, 1'b1);
        rd(NPT, 32'h0000_2001, 1'b0);
        acc(1'b1, NPT, 16'hFFFF, 1'b1);
        rd(NPT, 32'h0000_B7FF, 1'b0);
        pstrb <= 4'h2;
        acc(1'b1, NPT, 16'h0000, 1'b0);
        pstrb <= 4'hF;
        rd(NPT, 32'h0000_00FF, 1'b0);
        wait_sent();
        chk("taken", {17'h0, u_anp_line_partner.taken}, 32'h0000_00FF);
        rd(NPT, 32'h0000_08FF, 1'b0);
        dly <= 4'h1;
        acc(1'b1, NPT, 16'h8155, 1'b0);
        wait_sent();
        chk("taken", {17'h0, u_anp_line_partner.taken}, 32'h0000_4955);
        rd(NPT, 32'h0000_8155, 1'b0);
        u_anp_line_partner.pulse(1'b1, 1'b1, 1'b1, 1'b1);
        @(posedge pclk);
        rd(EXP, 32'h0000_001F, 1'b0);
        rd(EXP, 32'h0000_000D, 1'b0);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, EXP, LOC_W[i], 1'b0);
            repeat (2) @(posedge pclk);
            chk("rx_store_index", {24'h0, rx_store_index}, {24'h0, LOC_IX[i]});
        end
        rd(EXP, 32'h0000_002D, 1'b0);
        acc(1'b1, 8'h3C, 16'hFFFF, 1'b0);
        chk("pslverr", {31'h0, err}, 32'h0000_0001);
        rd(8'h3C, 32'h0000_0000, 1'b0);
        rd(NPT, 32'h0000_8155, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(NPT, 32'h0000_2001, 1'b0);
        chk("rx_store_index", {24'h0, rx_store_index}, 32'h0000_0005);
        test_done();
    end
endmodule
